//--- design/fpec_map.svh
// Register indices, field positions, reset values and timing counts
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define FPEC_CTRL_IDX 16'hFE08
`define FPEC_PROT_IDX 16'hFF81
`define FPEC_STAT_IDX 16'hFE0A

// Control register fields
`define FPEC_BIT_PROGRAM 0
`define FPEC_BIT_ERASE 1
`define FPEC_BIT_MASS 2
`define FPEC_BIT_HV_EN 3
`define FPEC_CTRL_RST 4'h0

// Status register fields, write one to clear bits 0 to 3
`define FPEC_ST_ROW_FAIL 0
`define FPEC_ST_EARLY_WR 1
`define FPEC_ST_HV_REFUSED 2
`define FPEC_ST_BAD_SEL 3
`define FPEC_ST_STANDBY 4
`define FPEC_ST_LATCHED 5
`define FPEC_ST_PROT_READ 6
`define FPEC_ST_HV_ON 7

// Second array user space
`define FPEC_A2_LO0 16'h0462
`define FPEC_A2_HI0 16'h04FF
`define FPEC_A2_LO1 16'h0980
`define FPEC_A2_HI1 16'h1B7F
`define FPEC_A2_LO2 16'h1E20
`define FPEC_A2_HI2 16'h7FFF
`define FPEC_PROT_NONE 8'hFF

// Timing
`define FPEC_CLK_MHZ 125
`define FPEC_SETUP_US 10
`define FPEC_START_US 5
`define FPEC_SETUP_CYC (`FPEC_SETUP_US * `FPEC_CLK_MHZ)
`define FPEC_START_CYC (`FPEC_START_US * `FPEC_CLK_MHZ)

`endif

//--- design/fpec_pkg.sv
// Types shared by the flash program and erase controller
package fpec_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SEL   = 6'h02,
    ST_PROT  = 6'h04,
    ST_LATCH = 6'h08,
    ST_HV    = 6'h10,
    ST_CLOSE = 6'h20
  } fpec_seq_e;

  typedef struct packed {
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
  } fpec_ctrl_s;

  // Controls towards the second array macro
  typedef struct packed {
    logic standby;
    logic hv;
    logic program_select;
    logic erase;
    logic mass;
    logic wr_pulse;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fpec_arr_s;

endpackage

//--- design/fpec_elapse_timer.sv
// Elapsed-time tracker: flags when a minimum wait has passed
`timescale 1ns/100ps
module fpec_elapse_timer #(
  parameter int unsigned CYCLES = 1250
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic restart,
  input wire logic run,
  // Result
  output logic done
);
  import fpec_pkg::*;

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LIMIT = W'(CYCLES);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fpec_tmr_s;

  fpec_tmr_s q, d;

  initial begin
    if (CYCLES < 1 || CYCLES > 4096) begin
      $error("fpec_elapse_timer: CYCLES out of range");
    end
  end

  // Saturating count keeps done high until the next restart
  always_comb begin
    d = q;
    if (restart) begin
      d.cnt = '0;
    end else if (run && q.cnt != LIMIT) begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = (q.cnt == LIMIT);

  chk_done_exact: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done) |-> $past(q.cnt) == LIMIT - W'(1) && $past(run))
    else $error("timer done without full count");

endmodule

//--- design/fpec_prot_check.sv
// Protected-range decode for the second array
`timescale 1ns/100ps
`include "fpec_map.svh"
module fpec_prot_check (
  // Protect byte and address under test
  input wire logic [7:0] prot_byte,
  input wire logic [15:0] addr,
  // Result
  output logic hit,
  output logic any_prot
);
  import fpec_pkg::*;

  logic [15:0] start;

  assign start = {1'b0, prot_byte, 7'h00};
  assign any_prot = (prot_byte != `FPEC_PROT_NONE);
  assign hit = any_prot && addr >= start && addr <= `FPEC_A2_HI2;

endmodule

//--- design/fpec_flash_ctrl.sv
// Second-array program/erase controller with AHB-Lite register port
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`include "fpec_map.svh"

// Functional notes
// - Programming covers one aligned 64-byte row; other-row writes fail.
// - Program select enables latching of address and data from array writes.
// - Wait mode suspends operation into standby; no effect in read mode.
// - Stop mode suspends operation into standby; other array controls inactive.
// - Erased bits read one, two 64-byte rows per 128-byte page.
// - Array space at 0462, 0980, 1E20 ranges; control FE08, protect FF81.
// - High voltage sets only with a select and full preparatory sequence.
// - Mass bit chooses mass erase when one, page erase when zero.
// - Program and erase selects never both one; setting both is refused.
// - Protect byte lives in first array and is read-only here.
// - High voltage refused when the latched location is protected.
// - Protect byte gives address bits 14 to 7; range ends at 7FFF.
module fpec_flash_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // First array protect byte and second array read data
  input wire logic [7:0] prot_byte,
  input wire logic [7:0] arr_rdata,
  // Low-power modes
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Array controls
  output logic [15:0] arr_raddr,
  output fpec_pkg::fpec_arr_s arr
);
  import fpec_pkg::*;

  typedef struct packed {
    fpec_seq_e seq;
    fpec_ctrl_s ctrl;
    logic wr_pend;
    logic [15:0] wr_idx;
    logic [31:0] rdata;
    logic [15:0] lat_addr;
    logic [7:0] lat_data;
    logic wpulse;
    logic row_fail;
    logic early_wr;
    logic hv_refused;
    logic bad_sel;
  } fpec_state_s;

  fpec_state_s q, d;

  logic ap_valid;
  logic [15:0] ap_idx;
  logic [7:0] wd;
  logic wr_ctrl, wr_stat, wr_arr;
  logic ap_in_arr, wr_in_arr;
  logic sel_any, susp;
  logic nvs_done, pgs_done;
  logic prot_hit, any_prot;
  logic hv_ok, hv_req, hv_grant;
  logic new_program, new_erase, both_req;
  logic program_on, hv_on;
  logic nvs_restart, pgs_restart;
  logic set_row_fail, set_early, set_refused, set_bad_sel;
  logic [7:0] status;
  logic [7:0] rd_mux;

  function automatic logic in_array2(input logic [15:0] a);
    in_array2 = (a >= `FPEC_A2_LO0 && a <= `FPEC_A2_HI0) ||
                (a >= `FPEC_A2_LO1 && a <= `FPEC_A2_HI1) ||
                (a >= `FPEC_A2_LO2 && a <= `FPEC_A2_HI2);
  endfunction

  // Bus decode: one word per location index
  assign ap_valid = hsel && htrans[1] && hready;
  assign ap_idx = haddr[17:2];
  assign wd = hwdata[7:0];
  assign ap_in_arr = in_array2(ap_idx);
  assign wr_in_arr = in_array2(q.wr_idx);
  assign wr_ctrl = q.wr_pend && q.wr_idx == `FPEC_CTRL_IDX;
  assign wr_stat = q.wr_pend && q.wr_idx == `FPEC_STAT_IDX;
  assign wr_arr = q.wr_pend && wr_in_arr;

  assign program_on = q.ctrl.program_select;
  assign hv_on = q.ctrl.high_voltage_enable;
  assign sel_any = program_on || q.ctrl.erase;
  // suspend only while an operation is in progress
  assign susp = (wait_mode || stop_mode) && (sel_any || hv_on);

  fpec_prot_check u_prot (
    .prot_byte(prot_byte),
    .addr(q.lat_addr),
    .hit(prot_hit),
    .any_prot(any_prot)
  );

  fpec_elapse_timer #(
    .CYCLES(`FPEC_SETUP_CYC)
  ) u_nvs (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(nvs_restart),
    .run(q.seq == ST_LATCH),
    .done(nvs_done)
  );

  fpec_elapse_timer #(
    .CYCLES(`FPEC_START_CYC)
  ) u_pgs (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(pgs_restart),
    .run(q.seq == ST_HV),
    .done(pgs_done)
  );

  // full preparatory sequence, setup time met, not suspended
  // mass erase needs the whole array unprotected
  assign hv_ok = sel_any && q.seq == ST_LATCH && nvs_done && !prot_hit &&
                 !(q.ctrl.erase && q.ctrl.mass && any_prot) && !susp &&
                 new_program == program_on && new_erase == q.ctrl.erase &&
                 wd[`FPEC_BIT_MASS] == q.ctrl.mass;
  assign hv_req = wr_ctrl && wd[`FPEC_BIT_HV_EN] && !hv_on;
  assign hv_grant = hv_req && hv_ok;

  // a write asking for both selects keeps the old pair
  assign both_req = wd[`FPEC_BIT_PROGRAM] && wd[`FPEC_BIT_ERASE];
  assign new_program = both_req ? program_on : wd[`FPEC_BIT_PROGRAM];
  assign new_erase = both_req ? q.ctrl.erase : wd[`FPEC_BIT_ERASE];

  assign nvs_restart = wr_arr && sel_any && q.seq == ST_PROT;
  assign pgs_restart = hv_grant;

  // byte writes outside the latched row fail the cycle
  assign set_row_fail = wr_arr && q.seq == ST_HV && program_on &&
                        q.wr_idx[15:6] != q.lat_addr[15:6];
  assign set_early = wr_arr && q.seq == ST_HV && program_on && !pgs_done;
  assign set_refused = hv_req && !hv_ok;
  assign set_bad_sel = wr_ctrl && both_req;

  always_comb begin
    status = 8'h00;
    status[`FPEC_ST_ROW_FAIL] = q.row_fail;
    status[`FPEC_ST_EARLY_WR] = q.early_wr;
    status[`FPEC_ST_HV_REFUSED] = q.hv_refused;
    status[`FPEC_ST_BAD_SEL] = q.bad_sel;
    status[`FPEC_ST_STANDBY] = susp;
    status[`FPEC_ST_LATCHED] = (q.seq == ST_LATCH) || (q.seq == ST_HV);
    status[`FPEC_ST_PROT_READ] = (q.seq == ST_PROT);
    status[`FPEC_ST_HV_ON] = hv_on;
  end

  always_comb begin
    rd_mux = 8'h00;
    if (ap_idx == `FPEC_CTRL_IDX) begin
      rd_mux = {4'h0, hv_on, q.ctrl.mass, q.ctrl.erase, program_on};
    end else if (ap_idx == `FPEC_PROT_IDX) begin
      // protect byte is only read here
      rd_mux = prot_byte;
    end else if (ap_idx == `FPEC_STAT_IDX) begin
      rd_mux = status;
    end else if (ap_in_arr) begin
      // array data passes as stored, erased bits as ones
      rd_mux = arr_rdata;
    end
  end

  always_comb begin
    d = q;
    d.wpulse = 1'b0;
    d.wr_pend = ap_valid && hwrite;
    if (ap_valid) begin
      d.wr_idx = ap_idx;
    end
    if (ap_valid && !hwrite) begin
      d.rdata = {24'h000000, rd_mux};
      // protect read follows the select step
      if (ap_idx == `FPEC_PROT_IDX && q.seq == ST_SEL) begin
        d.seq = ST_PROT;
      end
    end

    if (wr_ctrl) begin
      d.ctrl.program_select = new_program;
      d.ctrl.erase = new_erase;
      d.ctrl.mass = wd[`FPEC_BIT_MASS];
      if (!wd[`FPEC_BIT_HV_EN]) begin
        d.ctrl.high_voltage_enable = 1'b0;
      end else if (hv_grant) begin
        d.ctrl.high_voltage_enable = 1'b1;
      end
      if (!new_program && !new_erase) begin
        d.seq = (d.ctrl.high_voltage_enable) ? ST_CLOSE : ST_IDLE;
      end else if (new_program != program_on ||
                   new_erase != q.ctrl.erase) begin
        // Changing the operation restarts the preparatory sequence
        d.seq = ST_SEL;
      end else if (hv_grant) begin
        d.seq = ST_HV;
      end
      if (q.seq == ST_CLOSE && !d.ctrl.high_voltage_enable &&
          !new_program && !new_erase) begin
        d.seq = ST_IDLE;
      end
    end

    // array writes ignored without a select
    if (wr_arr && sel_any) begin
      case (q.seq)
        ST_PROT: begin
          // first write latches the row or page address
          d.lat_addr = q.wr_idx;
          d.lat_data = wd;
          d.seq = ST_LATCH;
        end
        ST_HV: begin
          // program write latches address and data
          if (program_on && !set_row_fail) begin
            d.lat_addr = q.wr_idx;
            d.lat_data = wd;
            d.wpulse = 1'b1;
          end
        end
        default: begin
          d.seq = q.seq;
        end
      endcase
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    if (wr_stat) begin
      d.row_fail = q.row_fail && !wd[`FPEC_ST_ROW_FAIL];
      d.early_wr = q.early_wr && !wd[`FPEC_ST_EARLY_WR];
      d.hv_refused = q.hv_refused && !wd[`FPEC_ST_HV_REFUSED];
      d.bad_sel = q.bad_sel && !wd[`FPEC_ST_BAD_SEL];
    end
    d.row_fail = d.row_fail || set_row_fail;
    d.early_wr = d.early_wr || set_early;
    d.hv_refused = d.hv_refused || set_refused;
    d.bad_sel = d.bad_sel || set_bad_sel;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.seq <= ST_IDLE;
      q.ctrl <= `FPEC_CTRL_RST;
      q.wr_pend <= 1'b0;
      q.wr_idx <= 16'h0000;
      q.rdata <= 32'h00000000;
      q.lat_addr <= 16'h0000;
      q.lat_data <= 8'hFF;
      q.wpulse <= 1'b0;
      q.row_fail <= 1'b0;
      q.early_wr <= 1'b0;
      q.hv_refused <= 1'b0;
      q.bad_sel <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Zero-wait slave; read data is registered at the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign arr_raddr = ap_idx;

  // suspension raises standby and forces the other array controls inactive
  always_comb begin
    arr.standby = susp;
    arr.hv = hv_on && !susp;
    arr.program_select = program_on && !susp;
    arr.erase = q.ctrl.erase && !susp;
    arr.mass = q.ctrl.mass && q.ctrl.erase && !susp;
    arr.wr_pulse = q.wpulse && !susp;
    arr.addr = q.lat_addr;
    arr.wdata = q.lat_data;
  end

  chk_sel_interlock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(program_on && q.ctrl.erase))
    else $error("program and erase selected together");

  chk_hv_sequence: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hv_on) |-> $past(q.seq) == ST_LATCH && $past(nvs_done)
      && q.seq == ST_HV)
    else $error("high voltage set outside sequence");

  chk_hv_protect: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hv_req && prot_hit |=> !hv_on && q.hv_refused)
    else $error("high voltage set on protected location");

  chk_mass_guard: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hv_req && q.ctrl.mass && q.ctrl.erase && any_prot |=> !hv_on)
    else $error("mass erase allowed with protection");

  chk_row_bound: assert property (
    @(posedge hclk) disable iff (!hresetn)
    set_row_fail |=> q.row_fail && !q.wpulse && $stable(q.lat_addr))
    else $error("other-row write not failed");

  chk_latch_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_arr && sel_any && q.seq == ST_PROT |=>
      q.seq == ST_LATCH && q.lat_addr == $past(q.wr_idx))
    else $error("select write not latched");

  chk_idle_ignore: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_arr && !sel_any |=> $stable(q.lat_addr) && !q.wpulse)
    else $error("array write latched without select");

  chk_susp_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    susp |-> arr.standby && !arr.hv && !arr.program_select && !arr.erase
      && !arr.wr_pulse)
    else $error("array active while suspended");

  chk_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wait_mode || stop_mode) && !sel_any && !hv_on |-> !arr.standby)
    else $error("standby entered in read mode");

  chk_prot_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ap_valid && !hwrite && ap_idx == `FPEC_PROT_IDX && q.seq == ST_SEL
      && !wr_ctrl |=> q.seq == ST_PROT)
    else $error("protect read did not advance sequence");

endmodule

//--- dv/fpec_tb.sv
// Self-checking bench for the flash program and erase controller
`timescale 1ns/100ps
module testbench;
  import fpec_pkg::*;

  localparam logic [31:0] CTRL = 32'h0003F820;
  localparam logic [31:0] PROT = 32'h0003FE04;
  localparam logic [31:0] STAT = 32'h0003F828;
  localparam logic [31:0] NOMAP = 32'h0003F800;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] prot_byte = 8'hFF;
  logic [7:0] arr_rdata = 8'hFF;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] arr_raddr;
  fpec_arr_s arr;
  wire logic hready;
  int bad_count = 0;
  int num_checks = 0;
  int pulses = 0;
  logic [15:0] p_addr = 16'h0;
  logic [7:0] p_data = 8'h0;

  assign hready = hreadyout;

  always #4 hclk = ~hclk;

  fpec_flash_ctrl i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .prot_byte(prot_byte),
    .arr_rdata(arr_rdata),
    .wait_mode(wait_mode),
    .stop_mode(stop_mode),
    .arr_raddr(arr_raddr),
    .arr(arr)
  );

  // Byte strobes to the array are counted so lost or extra ones show up
  always @(posedge hclk) begin
    if (arr.wr_pulse === 1'b1) begin
      pulses++;
      p_addr = arr.addr;
      p_data = arr.wdata;
    end
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One idle edge before each transfer keeps reads clear of a pending write
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a,
                        input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk_word(nm, e, r);
  endtask

  function automatic logic [31:0] loc(input logic [15:0] l);
    return {14'h0, l, 2'b00};
  endfunction

  // select, read the protect byte, write into the page or row
  // only a real array location is touched between steps
  task automatic prep(input logic [31:0] sel, input logic [15:0] l,
                      input int gap);
    wr(CTRL, sel);
    rd_chk("protect byte", PROT, {24'h0, prot_byte});
    wr(loc(l), 32'h000000A5);
    repeat (gap) @(posedge hclk);
    wr(CTRL, sel | 32'h8);
  endtask

  // drop the select, hold high voltage 5 us, recover 1 us
  task automatic close_op;
    wr(CTRL, 32'h8);
    repeat (625) @(posedge hclk);
    wr(CTRL, 32'h0);
    repeat (125) @(posedge hclk);
    wr(STAT, 32'hF);
  endtask

  task automatic t_reset;
    rd_chk("ctrl reset", CTRL, 32'h0);
    rd_chk("stat reset", STAT, 32'h0);
    rd_chk("unmapped", NOMAP, 32'h0);
    wr(PROT, 32'h0);
    rd_chk("protect ro", PROT, 32'hFF);
    @(negedge hclk);
    chk_bit("hv idle", 1'b0, arr.hv);
    @(posedge hclk);
    wait_mode <= 1'b1;
    stop_mode <= 1'b1;
    arr_rdata <= 8'h5C;
    @(negedge hclk);
    chk_bit("read mode standby", 1'b0, arr.standby);
    rd_chk("array read", loc(16'h0980), 32'h5C);
    chk_word("array raddr", 32'h0980, {16'h0, arr_raddr});
    chk_bit("bus okay", 1'b0, hresp);
    rd_chk("read mode stat", STAT, 32'h0);
    @(posedge hclk);
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
    arr_rdata <= 8'hFF;
  endtask

  task automatic t_interlock;
    wr(CTRL, 32'h3);
    rd_chk("both selects", CTRL, 32'h0);
    rd_chk("bad select", STAT, 32'h8);
    wr(CTRL, 32'h1);
    wr(CTRL, 32'h3);
    rd_chk("keep program", CTRL, 32'h1);
    close_op();
  endtask

  task automatic t_hv_refuse;
    wr(CTRL, 32'h8);
    rd_chk("hv no select", CTRL, 32'h0);
    close_op();
    prep(32'h1, 16'h2000, 100);
    rd_chk("hv too early", CTRL, 32'h1);
    rd_chk("refused flag", STAT, 32'h24);
    close_op();
  endtask

  task automatic t_program;
    wr(loc(16'h2010), 32'h11);
    rd_chk("no latch", STAT, 32'h0);
    chk_word("idle pulses", 32'd0, pulses);
    prep(32'h1, 16'h2000, 1250);
    rd_chk("hv granted", CTRL, 32'h9);
    @(negedge hclk);
    chk_bit("hv on", 1'b1, arr.hv);
    chk_bit("prog on", 1'b1, arr.program_select);
    // erased bytes only, one short burst on the row
    // The first byte lands before the start delay on purpose
    wr(loc(16'h2005), 32'h5A);
    rd_chk("early byte", STAT, 32'hA2);
    chk_word("pulse count", 32'd1, pulses);
    chk_word("byte addr", 32'h2005, {16'h0, p_addr});
    chk_word("byte data", 32'h5A, {24'h0, p_data});
    // 30 us per byte, well short of the byte maximum
    repeat (3750) @(posedge hclk);
    wr(loc(16'h203F), 32'h3C);
    rd_chk("row end", STAT, 32'hA2);
    chk_word("row end pulse", 32'h203F, {16'h0, p_addr});
    wr(loc(16'h2040), 32'h77);
    rd_chk("row fail", STAT, 32'hA3);
    chk_word("other row", 32'd2, pulses);
    @(posedge hclk);
    wait_mode <= 1'b1;
    @(negedge hclk);
    chk_bit("wait standby", 1'b1, arr.standby);
    chk_bit("wait hv", 1'b0, arr.hv);
    @(posedge hclk);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    @(negedge hclk);
    chk_bit("stop standby", 1'b1, arr.standby);
    chk_bit("stop prog", 1'b0, arr.program_select);
    @(posedge hclk);
    stop_mode <= 1'b0;
    @(negedge hclk);
    chk_bit("resume hv", 1'b1, arr.hv);
    wr(CTRL, 32'h8);
    @(negedge hclk);
    chk_bit("hold hv", 1'b1, arr.hv);
    chk_bit("prog off", 1'b0, arr.program_select);
    close_op();
    @(negedge hclk);
    chk_bit("hv off", 1'b0, arr.hv);
  endtask

  task automatic t_erase;
    @(posedge hclk);
    prot_byte <= 8'h40;
    prep(32'h2, 16'h2000, 1250);
    rd_chk("protected page", CTRL, 32'h2);
    close_op();
    prep(32'h2, 16'h1FFF, 1250);
    rd_chk("below start", CTRL, 32'hA);
    @(negedge hclk);
    chk_bit("page erase", 1'b1, arr.erase);
    chk_bit("page not mass", 1'b0, arr.mass);
    // erase hold kept short; the device does not time it
    close_op();
    prep(32'h6, 16'h1FFF, 1250);
    rd_chk("mass protected", CTRL, 32'h6);
    close_op();
    @(posedge hclk);
    prot_byte <= 8'hFF;
    prep(32'h6, 16'h0462, 1250);
    rd_chk("mass granted", CTRL, 32'hE);
    @(negedge hclk);
    chk_bit("mass on", 1'b1, arr.mass);
    close_op();
  endtask

  // About 16300 cycles of sequences and host waits fit well inside
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_interlock();
    t_hv_refuse();
    t_program();
    t_erase();
    print_verdict();
  end
endmodule
